//--- ubr_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef UBR_REGS_SVH
`define UBR_REGS_SVH
`define UBR_OFS_DATA     3'h0
`define UBR_OFS_DIVH     3'h1
`define UBR_OFS_FIFO     3'h2
`define UBR_OFS_LCTL     3'h3
`define UBR_OFS_MCTL     3'h4
`define UBR_OFS_LSTAT    3'h5
`define UBR_OFS_MSTAT    3'h6
`define UBR_OFS_SCRATCH  3'h7
`define UBR_LCTL_LATCH   7
`define UBR_DIVH_SEL     7
`define UBR_STAT_RX_RDY  0
`define UBR_STAT_TX_EMPTY 5
`define UBR_STAT_TX_IDLE 6
`define UBR_RST_BYTE     8'h00
`define UBR_IDENT_NONE   8'h01
`define UBR_SRC_SLOW_HZ  1843200
`define UBR_SRC_FAST_HZ  24000000
`define UBR_OVERSAMPLE   16
`endif

//--- ubr_pkg.sv
// types for the uart register window
package ubr_pkg;
	typedef enum logic [1:0] {UBR_IDLE, UBR_START, UBR_DATA, UBR_STOP} ubr_line_e;
	typedef struct packed {
		logic       cs;
		logic       wr;
		logic       rd;
		logic [2:0] ofs;
		logic [7:0] wdata;
	} ubr_req_s;
	typedef struct packed {
		logic [7:0]  rx_data;
		logic [7:0]  tx_data;
		logic        tx_full;
		logic        rx_ready;
		logic [7:0]  dll;
		logic [7:0]  dlm;
		logic [7:0]  int_en;
		logic [7:0]  line_ctl;
		logic [7:0]  modem_ctl;
		logic [7:0]  scratch;
		logic [7:0]  fifo_ctl;
		logic [15:0] baud_cnt;
		logic        tick;
		ubr_line_e   tx_st;
		logic [3:0]  tx_os;
		logic [2:0]  tx_bit;
		logic [7:0]  tx_sh;
		logic        txd;
		ubr_line_e   rx_st;
		logic [3:0]  rx_os;
		logic [2:0]  rx_bit;
		logic [7:0]  rx_sh;
		logic [2:0]  rxd_sync;
		logic        rxd_st;
		logic [7:0]  rdata;
	} ubr_state_s;
endpackage

//--- ubr_uart.sv
// uart runtime register window with double-buffered data path
// What this block does
// - fast source divisors 24/2/1 give table rates
// - host reaches registers at base plus offset
// - controller uses fixed base plus same offset
// - line control bit 7 selects offsets 0,1
// - offset 0: divisor low or data buffers
// - offset 1: divisor high or interrupt enable
// - receive data read-only, reset zero, latest char
// - serial bits go least significant first
// - hidden shift register fills receive data
// - transmit data write-only, reset zero
// - transmit shifter loads after previous byte done
// - baud tick at sixteen times baud rate
// - source select bit picks slow or fast
// - offset 2 writes fifo control, reads ident
`include "ubr_regs.svh"
module ubr_uart
	import ubr_pkg::*;
#(
	parameter logic [15:0] BASE_ADDR = 16'h03f8
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// register access, full host address decoded against BASE_ADDR here
	input  wire logic        acc_cs,
	input  wire logic        acc_wr,
	input  wire logic        acc_rd,
	input  wire logic [15:0] acc_addr,
	input  wire logic [7:0]  acc_wdata,
	output logic      [7:0]  acc_rdata,
	// baud sources, one-cycle enables at source rate
	input  wire logic        slow_src_en,
	input  wire logic        fast_src_en,
	input  wire logic        ext_src_en,
	input  wire logic        external_clock_choice,
	// serial line
	input  wire logic        rxd,
	output logic             txd,
	output logic             baud_tick
);
	if (BASE_ADDR[2:0] != 3'h0)
	begin : g_base_chk
		$error("base address must be 8-byte aligned");
	end

	ubr_state_s s;
	ubr_state_s next_s;
	ubr_req_s   req;
	logic       src_en;
	logic       divisor_access_latch_bit;
	logic       wr_data;
	logic       rd_data;
	logic [15:0] divisor;

	// ----------------------------------------------------------
	// address decode
	// ----------------------------------------------------------
	function automatic logic hit(input logic [15:0] a);
		hit = (a[15:3] == BASE_ADDR[15:3]);
	endfunction

	always_comb
	begin
		req.cs    = acc_cs && hit(acc_addr);
		req.wr    = acc_wr;
		req.rd    = acc_rd;
		req.ofs   = acc_addr[2:0];
		req.wdata = acc_wdata;
	end

	assign divisor_access_latch_bit = s.line_ctl[`UBR_LCTL_LATCH];
	assign wr_data = req.cs && req.wr && req.ofs == `UBR_OFS_DATA && !divisor_access_latch_bit;
	assign rd_data = req.cs && req.rd && req.ofs == `UBR_OFS_DATA && !divisor_access_latch_bit;
	assign divisor = {1'b0, s.dlm[6:0], s.dll};

	// source select: external choice wins, else divisor high bit 7 chooses fast source
	always_comb
	begin
		if (external_clock_choice)
			src_en = ext_src_en;
		else if (s.dlm[`UBR_DIVH_SEL])
			src_en = fast_src_en;
		else
			src_en = slow_src_en;
	end

	// ----------------------------------------------------------
	// next state
	// ----------------------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		next_s.rxd_sync = {s.rxd_sync[1:0], rxd};
		if (s.rxd_sync[2] == s.rxd_sync[1])
			next_s.rxd_st = s.rxd_sync[2];

		// baud generator, 16x the baud rate
		if (src_en)
		begin
			if (s.baud_cnt <= 16'h0001)
			begin
				next_s.baud_cnt = (divisor == 16'h0000) ? 16'h0003 : divisor;
				next_s.tick = 1'b1;
			end
			else
				next_s.baud_cnt = s.baud_cnt - 16'h0001;
		end

		// register writes
		if (req.cs && req.wr)
		begin
			if (req.ofs == `UBR_OFS_DATA)
			begin
				if (divisor_access_latch_bit)
				begin
					next_s.dll = req.wdata;
					next_s.baud_cnt = {1'b0, s.dlm[6:0], req.wdata};
				end
				else
				begin
					next_s.tx_data = req.wdata;
					next_s.tx_full = 1'b1;
				end
			end
			else if (req.ofs == `UBR_OFS_DIVH)
			begin
				if (divisor_access_latch_bit)
				begin
					next_s.dlm = req.wdata;
					next_s.baud_cnt = {1'b0, req.wdata[6:0], s.dll};
				end
				else
					next_s.int_en = {4'h0, req.wdata[3:0]};
			end
			else if (req.ofs == `UBR_OFS_FIFO)
				next_s.fifo_ctl = req.wdata;
			else if (req.ofs == `UBR_OFS_LCTL)
				next_s.line_ctl = req.wdata;
			else if (req.ofs == `UBR_OFS_MCTL)
				next_s.modem_ctl = req.wdata;
			else if (req.ofs == `UBR_OFS_SCRATCH)
				next_s.scratch = req.wdata;
		end

		// transmitter, bit 0 first
		if (s.tick)
		begin
			next_s.tx_os = s.tx_os + 4'h1;
			case (s.tx_st)
				UBR_IDLE:
				begin
					next_s.txd = 1'b1;
					if (s.tx_full)
					begin
						next_s.tx_sh = s.tx_data;
						next_s.tx_full = 1'b0;
						next_s.tx_st = UBR_START;
						next_s.tx_os = 4'h0;
						next_s.txd = 1'b0;
					end
				end
				UBR_START:
					if (s.tx_os == 4'hf)
					begin
						next_s.tx_st = UBR_DATA;
						next_s.tx_bit = 3'h0;
						next_s.txd = s.tx_sh[0];
					end
				UBR_DATA:
					if (s.tx_os == 4'hf)
					begin
						next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
						next_s.txd = s.tx_sh[1];
						next_s.tx_bit = s.tx_bit + 3'h1;
						if (s.tx_bit == 3'h7)
						begin
							next_s.tx_st = UBR_STOP;
							next_s.txd = 1'b1;
						end
					end
				default:
					if (s.tx_os == 4'hf)
						next_s.tx_st = UBR_IDLE;
			endcase
		end
		if (wr_data && s.tx_st == UBR_IDLE && s.tx_full)
			next_s.tx_full = 1'b1;

		// receiver, samples mid-bit
		if (s.tick)
		begin
			next_s.rx_os = s.rx_os + 4'h1;
			case (s.rx_st)
				UBR_IDLE:
					if (!s.rxd_st)
					begin
						next_s.rx_st = UBR_START;
						next_s.rx_os = 4'h1;
					end
				UBR_START:
					if (s.rx_os == 4'h7)
					begin
						next_s.rx_st = s.rxd_st ? UBR_IDLE : UBR_DATA;
						next_s.rx_os = 4'h0;
						next_s.rx_bit = 3'h0;
					end
				UBR_DATA:
					if (s.rx_os == 4'hf)
					begin
						next_s.rx_sh = {s.rxd_st, s.rx_sh[7:1]};
						next_s.rx_bit = s.rx_bit + 3'h1;
						if (s.rx_bit == 3'h7)
							next_s.rx_st = UBR_STOP;
					end
				default:
					if (s.rx_os == 4'hf)
					begin
						next_s.rx_st = UBR_IDLE;
						next_s.rx_data = s.rx_sh;
						next_s.rx_ready = 1'b1;
					end
			endcase
		end
		// completion wins over a read in the same cycle
		if (rd_data && !(s.tick && s.rx_st == UBR_STOP && s.rx_os == 4'hf))
			next_s.rx_ready = 1'b0;

		// read data
		next_s.rdata = 8'h00;
		if (req.cs && req.rd)
		begin
			if (req.ofs == `UBR_OFS_DATA)
				next_s.rdata = divisor_access_latch_bit ? s.dll : s.rx_data;
			else if (req.ofs == `UBR_OFS_DIVH)
				next_s.rdata = divisor_access_latch_bit ? s.dlm : s.int_en;
			else if (req.ofs == `UBR_OFS_FIFO)
				next_s.rdata = `UBR_IDENT_NONE;
			else if (req.ofs == `UBR_OFS_LCTL)
				next_s.rdata = s.line_ctl;
			else if (req.ofs == `UBR_OFS_MCTL)
				next_s.rdata = s.modem_ctl;
			else if (req.ofs == `UBR_OFS_LSTAT)
			begin
				next_s.rdata[`UBR_STAT_RX_RDY]   = s.rx_ready;
				next_s.rdata[`UBR_STAT_TX_EMPTY] = !s.tx_full;
				next_s.rdata[`UBR_STAT_TX_IDLE]  = !s.tx_full && s.tx_st == UBR_IDLE;
			end
			else if (req.ofs == `UBR_OFS_SCRATCH)
				next_s.rdata = s.scratch;
		end
	end

	// ----------------------------------------------------------
	// state register
	// ----------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s          <= '0;
			s.rx_data  <= `UBR_RST_BYTE;
			s.tx_data  <= `UBR_RST_BYTE;
			s.txd      <= 1'b1;
			s.rxd_sync <= 3'h7;
			s.rxd_st   <= 1'b1;
			s.tx_st    <= UBR_IDLE;
			s.rx_st    <= UBR_IDLE;
		end
		else
			s <= next_s;
	end

	assign acc_rdata = s.rdata;
	assign txd       = s.txd;
	assign baud_tick = s.tick;

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	sequence rx_done;
		s.tick && s.rx_st == UBR_STOP && s.rx_os == 4'hf;
	endsequence

	a_rx_update: assert property (@(posedge clk) disable iff (rst)
		rx_done |=> (s.rx_data == $past(s.rx_sh)) && s.rx_ready)
		else $error("receive data not updated on completion");
	a_rx_stable: assert property (@(posedge clk) disable iff (rst)
		!rx_done |=> s.rx_data == $past(s.rx_data))
		else $error("receive data changed without a character");
	a_read_keeps: assert property (@(posedge clk) disable iff (rst)
		rd_data && !(s.tick && s.rx_st == UBR_DATA && s.rx_os == 4'hf) |=> s.rx_sh == $past(s.rx_sh))
		else $error("read disturbed receive shifter");
	a_tx_load: assert property (@(posedge clk) disable iff (rst)
		s.tx_st != UBR_IDLE && $past(s.tx_st) != UBR_IDLE |-> !($fell(s.tx_full)))
		else $error("transmit shifter loaded mid character");
	a_tx_lsb: assert property (@(posedge clk) disable iff (rst)
		s.tick && s.tx_st == UBR_START && s.tx_os == 4'hf |=> s.txd == $past(s.tx_sh[0]))
		else $error("first data bit is not bit 0");
	a_latch_rd: assert property (@(posedge clk) disable iff (rst)
		req.cs && req.rd && req.ofs == `UBR_OFS_DATA && divisor_access_latch_bit |=> acc_rdata == $past(s.dll))
		else $error("divisor low byte not read with latch set");
	a_int_en_wr: assert property (@(posedge clk) disable iff (rst)
		req.cs && req.wr && req.ofs == `UBR_OFS_DIVH && !divisor_access_latch_bit |=> s.dlm == $past(s.dlm))
		else $error("divisor high written with latch clear");
	a_ident_rd: assert property (@(posedge clk) disable iff (rst)
		req.cs && req.rd && req.ofs == `UBR_OFS_FIFO |=> acc_rdata == `UBR_IDENT_NONE)
		else $error("offset 2 read not identification");
	a_div_one: assert property (@(posedge clk) disable iff (rst)
		divisor == 16'h0001 && src_en && !(req.cs && req.wr) |=> s.tick)
		else $error("divide by one missed a tick");
	a_src_sel: assert property (@(posedge clk) disable iff (rst)
		!external_clock_choice && s.dlm[`UBR_DIVH_SEL] |-> src_en == fast_src_en)
		else $error("fast source not selected");
endmodule // ubr_uart

//--- ubr_serial_peer.sv
// remote serial device model for the uart register window bench
module ubr_serial_peer #(
	parameter int BIT_CYC = 16
)(
	// clock
	input  wire logic clk,
	// serial line
	input  wire logic txd,
	output logic      rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [$];
	int         bad = 0;
	initial rxd = 1'b1;
	// ----------------------------------------
	// frame one byte onto rxd, line idles high
	// ----------------------------------------
	task automatic send(input logic [7:0] b);
		rxd <= 1'b0;
		repeat (BIT_CYC) @(negedge clk);
		for (int i = 0; i < 8; i++)
		begin
			rxd <= b[i];
			repeat (BIT_CYC) @(negedge clk);
		end
		rxd <= 1'b1;
		repeat (BIT_CYC) @(negedge clk);
	endtask
	// ----------------------------------------
	// capture frames from txd at mid-bit
	// ----------------------------------------
	initial
	forever
	begin : rx_loop
		logic [7:0] b;
		@(negedge txd);
		repeat (BIT_CYC / 2) @(negedge clk);
		if (txd === 1'b0)
		begin
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT_CYC) @(negedge clk);
				b[i] = txd;
			end
			repeat (BIT_CYC) @(negedge clk);
			if (txd !== 1'b1)
				bad++;
			got.push_back(b);
		end
	end
endmodule // ubr_serial_peer

//--- testbench.sv
// self-checking bench for the uart register window
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] BASE = 16'h0100;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cs = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata;
	logic [7:0]  last;
	logic        slow_en = 1'b0;
	logic        fast_en = 1'b1;
	logic        ext_en = 1'b0;
	logic        ext_choice = 1'b0;
	logic        rxd;
	logic        txd;
	logic        tick;
	int          cyc = 0;
	int          err_count = 0;
	int          checks_done = 0;
	logic [35:0] tab [7] = '{36'h8018_0_0018, 36'h8002_0_0002, 36'h8001_0_0001, 36'h8000_0_0003,
		36'h0002_0_0004, 36'h8002_1_0006, 36'h8100_0_0100};
	initial
	forever
		#20 clk = ~clk;
	// slow source every 2nd cycle, external every 3rd
	always @(negedge clk)
	begin
		cyc <= cyc + 1;
		slow_en <= (cyc % 2 == 0);
		ext_en <= (cyc % 3 == 0);
	end
	ubr_uart #(.BASE_ADDR(BASE)) DUT (.clk(clk), .rst(rst), .acc_cs(cs), .acc_wr(wr), .acc_rd(rd),
		.acc_addr(addr), .acc_wdata(wdata), .acc_rdata(rdata), .slow_src_en(slow_en),
		.fast_src_en(fast_en), .ext_src_en(ext_en), .external_clock_choice(ext_choice),
		.rxd(rxd), .txd(txd), .baud_tick(tick));
	ubr_serial_peer #(.BIT_CYC(16)) peer (.clk(clk), .txd(txd), .rxd(rxd));
	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] o, input logic [7:0] d);
		cs <= 1'b1;
		wr <= w;
		rd <= !w;
		addr <= BASE + o;
		wdata <= d;
		@(negedge clk);
		last = rdata;
		cs <= 1'b0;
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk);
	endtask
	task automatic wreg(input logic [15:0] o, input logic [7:0] d);
		acc(1'b1, o, d);
	endtask
	task automatic rreg(input logic [15:0] o, input logic [7:0] e, input logic [7:0] k, input string m);
		acc(1'b0, o, 8'h00);
		chk({8'h00, last & k}, {8'h00, e}, m);
	endtask
	task automatic gap(input logic [15:0] e);
		int n;
		for (int j = 0; j < 3; j++)
		begin
			n = 0;
			do
			begin
				@(negedge clk);
				n++;
			end while (tick !== 1'b1 && n < 600);
		end
		if (n >= 600)
		begin
			err_count++;
			$display("[FAIL] %0t no baud tick", $time);
			end_sim();
		end
		else
			chk(n[15:0], e, "tick gap");
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (4) @(negedge clk);
		rst <= 1'b0;
		rreg(3, 8'h00, 8'hff, "line ctl reset");
		rreg(1, 8'h00, 8'hff, "int enable reset");
		rreg(0, 8'h00, 8'hff, "rx data reset");
		rreg(2, 8'h01, 8'hff, "ident");
		wreg(3, 8'h80);
		rreg(0, 8'h00, 8'hff, "div low reset");
		rreg(1, 8'h00, 8'hff, "div high reset");
		wreg(0, 8'h5a);
		wreg(1, 8'h83);
		rreg(0, 8'h5a, 8'hff, "div low");
		rreg(1, 8'h83, 8'hff, "div high");
		wreg(2, 8'hc7);
		rreg(2, 8'h01, 8'hff, "ident latched");
		wreg(3, 8'h00);
		wreg(1, 8'hff);
		rreg(1, 8'h0f, 8'hff, "int enable");
		rreg(0, 8'h00, 8'hff, "rx data mux");
		wreg(7, 8'ha5);
		rreg(7, 8'ha5, 8'hff, "scratch");
		wreg(4, 8'h1f);
		rreg(4, 8'h1f, 8'hff, "modem ctl");
		wreg(5, 8'hff);
		rreg(5, 8'h60, 8'hff, "line status");
		rreg(6, 8'h00, 8'hff, "modem status");
		rreg(16'h0008, 8'h00, 8'hff, "outside window");
		wreg(16'h1003, 8'hff);
		rreg(3, 8'h00, 8'hff, "foreign write");
		wreg(3, 8'h80);
		rreg(0, 8'h5a, 8'hff, "div low kept");
		$display("register map test done");
		foreach (tab[i])
		begin
			ext_choice <= tab[i][16];
			wreg(0, tab[i][27:20]);
			wreg(1, tab[i][35:28]);
			gap(tab[i][15:0]);
		end
		ext_choice <= 1'b0;
		wreg(0, 8'h01);
		wreg(1, 8'h80);
		wreg(3, 8'h00);
		$display("baud rate test done");
		wreg(0, 8'ha5);
		wreg(0, 8'h3c);
		rreg(5, 8'h00, 8'h61, "busy status");
		rreg(0, 8'h00, 8'hff, "tx data hidden");
		for (int k = 0; k < 1000 && peer.got.size() < 2; k++)
			@(negedge clk);
		if (peer.got.size() < 2)
		begin
			err_count++;
			$display("[FAIL] %0t tx bytes missing", $time);
			end_sim();
		end
		chk({8'h00, peer.got[0]}, 16'h00a5, "tx first");
		chk({8'h00, peer.got[1]}, 16'h003c, "tx second");
		chk(peer.bad[15:0], 16'h0000, "tx stop bit");
		repeat (16) @(negedge clk);
		rreg(5, 8'h60, 8'h61, "tx idle");
		fork
			peer.send(8'h96);
			begin
				repeat (80) @(negedge clk);
				rreg(0, 8'h00, 8'hff, "rx mid frame");
			end
		join
		repeat (4) @(negedge clk);
		rreg(5, 8'h01, 8'h01, "rx ready");
		rreg(0, 8'h96, 8'hff, "rx byte");
		rreg(5, 8'h00, 8'h01, "rx ready clear");
		peer.send(8'h3b);
		repeat (4) @(negedge clk);
		rreg(0, 8'h3b, 8'hff, "rx latest");
		$display("serial test done");
		end_sim();
	end
endmodule // testbench
